//--- rtl/psoc_pkg.sv
// Shared constants and helpers for the serial position output block
package psoc_pkg;

  // Register indices on the configuration port
  localparam logic [1:0] PSOC_IDX_SERIAL_CFG = 2'h0;
  localparam logic [1:0] PSOC_IDX_PRELOAD_ONE = 2'h1;
  localparam logic [1:0] PSOC_IDX_PRELOAD_TWO = 2'h2;
  localparam logic [1:0] PSOC_IDX_VERNIER_VERNIER_OFFSET_VALUE = 2'h3;

  // Field positions in serial_output_config
  localparam int PSOC_BIT_IFACE_SEL = 31;
  localparam int PSOC_BIT_FRAME_WIDTH = 29;
  localparam int PSOC_BIT_RING = 28;
  localparam int PSOC_TMO_HI = 27;
  localparam int PSOC_TMO_LO = 16;
  localparam int PSOC_SRC_HI = 15;
  localparam int PSOC_SRC_LO = 14;
  localparam int PSOC_BIT_GRAY = 13;
  localparam int PSOC_RES_HI = 12;
  localparam int PSOC_RES_LO = 8;
  localparam int PSOC_BIT_WIDE_READ = 6;
  localparam int PSOC_EXP_HI = 4;
  localparam int PSOC_EXP_LO = 0;

  // Reserved bits 30, 7 and 5 are not stored and read as zero
  localparam logic [31:0] PSOC_CFG_WMASK = 32'hbfffff5f;

  // Values after reset
  localparam logic [31:0] PSOC_CFG_RESET = 32'hb2051e09;
  localparam logic [31:0] PSOC_PRELOAD_RESET = 32'h0000_0000;
  localparam logic [31:0] PSOC_VERNIER_OFFSET_VALUE_RESET = 32'h0000_0000;

  // Frame lengths and timeout offset
  localparam logic [5:0] PSOC_FRAME_LONG = 6'h20;
  localparam logic [5:0] PSOC_FRAME_SHORT = 6'h14;
  localparam logic [31:0] PSOC_SSI_TMO_ADD = 32'h0000_0003;
  localparam logic [1:0] PSOC_STRAP_SETTLE = 2'h3;

  // Position source selections
  typedef enum logic [1:0] {
    PSOC_SRC_VERNIER = 2'b00,
    PSOC_SRC_CH1 = 2'b01,
    PSOC_SRC_CH2 = 2'b10,
    PSOC_SRC_DEBUG = 2'b11
  } psoc_src_e;

  // Binary to Gray conversion
  function automatic logic [31:0] psoc_gray(input logic [31:0] v);
    psoc_gray = v ^ (v >> 1);
  endfunction

  // Keep the low res bits, clear the rest
  function automatic logic [31:0] psoc_mask(input logic [31:0] v, input logic [4:0] res);
    logic [31:0] m;
    m = ~(32'hffff_ffff << res);
    psoc_mask = v & m;
  endfunction

endpackage

//--- rtl/psoc_link_if.sv
// Carrier between the control domain and the link serializer
`timescale 1ns/1ps
`default_nettype none
interface psoc_link_if;
  logic [31:0] word;   // Frame word, quasi-static
  logic frame_long;    // 32-bit frame when high
  logic ring;          // Repeat frame when high
  logic rearm;         // Pulse returning serializer to start
  logic act_toggle;    // Flips on every rising link clock edge
  modport ctrl (output word, output frame_long, output ring, output rearm, input act_toggle);
  modport link (input word, input frame_long, input ring, input rearm, output act_toggle);
endinterface
`default_nettype wire

//--- rtl/psoc_link_ser.sv
// Link-clock serializer for position frames
`timescale 1ns/1ps
`default_nettype none
module psoc_link_ser
  import psoc_pkg::*;
(
  input wire logic link_clk_i,   // Clock from the external master
  input wire logic rst_n_i,      // Async reset, active low
  psoc_link_if.link lk,          // Control side
  output logic serial_data_o     // Serial data toward master
);

  typedef enum {PSOC_L_START, PSOC_L_SHIFT, PSOC_L_DONE} psoc_lst_e;

  psoc_lst_e state_r;            // Frame state
  logic [31:0] sh_r;             // Shift register
  logic [5:0] cnt_r;             // Bits still to send
  logic act_r;                   // Activity toggle
  wire logic lrst_n;             // Reset plus rearm from control domain
  wire logic [5:0] flen;         // Current frame length
  wire logic [31:0] aligned;     // Word moved to the top bits

  assign lrst_n = rst_n_i & ~lk.rearm;
  assign flen = lk.frame_long ? PSOC_FRAME_LONG : PSOC_FRAME_SHORT;
  assign aligned = lk.frame_long ? lk.word : {lk.word[19:0], 12'h000};
  assign lk.act_toggle = act_r;

  //////////////////////////////////////////////////////////////////////
  // Activity toggle, untouched by rearm
  always_ff @(posedge link_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i) act_r <= 1'b0;
    else act_r <= ~act_r;
  end

  //////////////////////////////////////////////////////////////////////
  // MSB-first shifting; rearm happens while the clock stands still
  always_ff @(posedge link_clk_i or negedge lrst_n)
  begin
    if (!lrst_n)
    begin
      state_r <= PSOC_L_START;
      sh_r <= 32'h0000_0000;
      cnt_r <= 6'h00;
      serial_data_o <= 1'b1;     // Idle line high
    end
    else
    begin
      unique case (state_r)
        PSOC_L_START:
        begin
          serial_data_o <= aligned[31];
          sh_r <= aligned << 1;
          cnt_r <= flen - 6'h01;
          state_r <= PSOC_L_SHIFT;
        end
        PSOC_L_SHIFT:
        begin
          if (cnt_r != 6'h00)
          begin
            serial_data_o <= sh_r[31];
            sh_r <= sh_r << 1;
            cnt_r <= cnt_r - 6'h01;
          end
          else if (lk.ring)      // Ring: resend same word
          begin
            serial_data_o <= aligned[31];
            sh_r <= aligned << 1;
            cnt_r <= flen - 6'h01;
          end
          else                   // Normal: frame over
          begin
            serial_data_o <= 1'b0;
            state_r <= PSOC_L_DONE;
          end
        end
        PSOC_L_DONE:
        begin
          serial_data_o <= 1'b0; // Hold low until timeout
        end
      endcase
    end
  end

endmodule // psoc_link_ser
`default_nettype wire

//--- rtl/psoc_timeout.sv
// Link activity monitor and timeout monoflop on the oscillator clock
`timescale 1ns/1ps
`default_nettype none
module psoc_timeout
(
  input wire logic clk_i,          // Oscillator clock
  input wire logic rst_n_i,        // Async reset, active low
  input wire logic act_toggle_i,   // Toggle from link domain
  input wire logic [31:0] limit_i, // Timeout in clock periods
  output logic busy_o,             // Frame in progress
  output logic rearm_o             // One-cycle end of timeout
);

  logic [2:0] sync_r;              // Three-stage synchronizer
  logic [31:0] cnt_r;              // Quiet cycles so far
  wire logic edge_seen;            // Second and third disagree

  assign edge_seen = sync_r[1] ^ sync_r[2];

  //////////////////////////////////////////////////////////////////////
  // Synchronize the activity toggle
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i) sync_r <= 3'h0;
    else sync_r <= {sync_r[1:0], act_toggle_i};
  end

  //////////////////////////////////////////////////////////////////////
  // Count quiet cycles; expire after limit_i of them
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cnt_r <= 32'h0000_0000;
      busy_o <= 1'b0;
      rearm_o <= 1'b0;
    end
    else
    begin
      rearm_o <= 1'b0;
      if (edge_seen)
      begin
        cnt_r <= 32'h0000_0000;
        busy_o <= 1'b1;
      end
      else if (busy_o)
      begin
        if (cnt_r >= limit_i - 32'h0000_0001)
        begin
          busy_o <= 1'b0;
          rearm_o <= 1'b1;
        end
        else cnt_r <= cnt_r + 32'h0000_0001;
      end
    end
  end

endmodule // psoc_timeout
`default_nettype wire

//--- rtl/psoc_top.sv
// Serial position output configuration, formatting and link top level
`timescale 1ns/1ps
`default_nettype none

//////////////////////////////////////////////////////////////////////////
module psoc_top
  import psoc_pkg::*;
(
  input wire logic clk_i,                      // Oscillator clock
  input wire logic rst_n_i,                    // Async reset, active low
  input wire logic link_clk_i,                 // Master clock pin
  input wire logic interface_enable_strap_i,   // Strap, low enables
  input wire logic reference_position_select_i, // Reference mode select
  input wire logic cfg_wr_i,                   // Register write strobe
  input wire logic cfg_rd_i,                   // Register read strobe
  input wire logic [1:0] cfg_addr_i,           // Register index
  input wire logic [31:0] cfg_wdata_i,         // Write data
  output logic [31:0] cfg_rdata_o,             // Read data
  output logic cfg_rvalid_o,                   // Read data valid
  input wire logic [31:0] vernier_pos_i,       // Vernier result
  input wire logic [31:0] ch1_count_i,         // Channel 1 counter
  input wire logic [31:0] ch2_count_i,         // Channel 2 counter
  output logic serial_enable_o,                // Serial interface on
  output logic ssi_mode_o,                     // SSI in use
  output logic biss_mode_o,                    // BiSS in use
  output logic wide_read_o,                    // 32-bit BiSS reads
  output logic [31:0] preload_one_o,           // Channel 1 preload
  output logic [31:0] preload_two_o,           // Channel 2 or vernier preload
  output logic [31:0] vernier_offset_o,        // Offset for vernier math
  output logic [15:0] ref_pos_first_o,         // Channel 1 reference
  output logic [15:0] ref_pos_second_o,        // Channel 2 reference
  output logic ref_pos_valid_o,                // References in use
  output logic frame_active_o,                 // Link frame running
  output logic serial_data_o                   // Serial data pin
);

  //////////////////////////////////////////////////////////////////////
  // Declarations
  logic [31:0] cfg_r;            // serial_output_config
  logic [31:0] pre1_r;           // preload_channel_one
  logic [31:0] pre2_r;           // preload_channel_two_vernier
  logic [31:0] vernier_offset_value_r;           // vernier_offset_reference
  logic [2:0] strap_sync_r;      // Strap synchronizer
  logic [1:0] strap_cnt_r;       // Settling count after release
  logic strap_done_r;            // Strap captured
  logic strap_en_r;              // Interface enabled by strap
  logic prime_r;                 // First snapshot after reset pending
  logic [31:0] word_r;           // Frame word snapshot
  logic frame_long_r;            // Width snapshot
  logic ring_r;                  // Ring snapshot
  logic busy;                    // Timeout monitor busy
  logic rearm;                   // Timeout expiry pulse

  psoc_link_if lk ();            // To the link serializer

  // Field views
  wire logic iface_ssi = cfg_r[PSOC_BIT_IFACE_SEL];
  wire logic frame_long = cfg_r[PSOC_BIT_FRAME_WIDTH];
  wire logic ring = cfg_r[PSOC_BIT_RING];
  wire logic [11:0] ssi_tmo = cfg_r[PSOC_TMO_HI:PSOC_TMO_LO];
  wire logic [1:0] src = cfg_r[PSOC_SRC_HI:PSOC_SRC_LO];
  wire logic gray = cfg_r[PSOC_BIT_GRAY];
  wire logic [4:0] res = cfg_r[PSOC_RES_HI:PSOC_RES_LO];
  wire logic [4:0] tmo_exp = cfg_r[PSOC_EXP_HI:PSOC_EXP_LO];

  //////////////////////////////////////////////////////////////////////
  // Position source selection and formatting
  wire logic [31:0] raw_pos;     // Selected source
  wire logic [31:0] res_pos;     // After resolution mask
  wire logic [31:0] fmt_pos;     // After optional Gray coding
  wire logic is_debug;           // Debug concatenation active

  assign is_debug = (src == PSOC_SRC_DEBUG);
  assign raw_pos = (src == PSOC_SRC_VERNIER) ? vernier_pos_i :
                   (src == PSOC_SRC_CH1) ? ch1_count_i :
                   (src == PSOC_SRC_CH2) ? ch2_count_i :
                   {ch1_count_i[15:0], ch2_count_i[15:0]};
  // Zeros above res; debug bypasses mask
  assign res_pos = is_debug ? raw_pos : psoc_mask(raw_pos, res);
  // Gray of a top-zero value keeps top zeros
  assign fmt_pos = gray ? psoc_gray(res_pos) : res_pos;

  //////////////////////////////////////////////////////////////////////
  // Interface mode and timeout limit
  wire logic [31:0] ssi_limit;   // SSI timeout cycles
  wire logic [31:0] biss_limit;  // BiSS timeout cycles
  wire logic [31:0] limit;       // Active limit

  assign ssi_limit = {20'h00000, ssi_tmo} + PSOC_SSI_TMO_ADD;
  assign biss_limit = 32'h0000_0001 << tmo_exp;
  assign limit = iface_ssi ? ssi_limit : biss_limit;

  assign serial_enable_o = strap_en_r;
  assign ssi_mode_o = strap_en_r & iface_ssi;
  assign biss_mode_o = strap_en_r & ~iface_ssi;
  assign wide_read_o = cfg_r[PSOC_BIT_WIDE_READ];
  assign frame_active_o = busy;

  //////////////////////////////////////////////////////////////////////
  // Preload and offset outputs
  assign preload_one_o = pre1_r;
  assign preload_two_o = pre2_r;
  assign vernier_offset_o = vernier_offset_value_r;
  assign ref_pos_first_o = vernier_offset_value_r[15:0];
  assign ref_pos_second_o = vernier_offset_value_r[31:16];
  assign ref_pos_valid_o = reference_position_select_i;

  //////////////////////////////////////////////////////////////////////
  // Register writes
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cfg_r <= PSOC_CFG_RESET;
      pre1_r <= PSOC_PRELOAD_RESET;
      pre2_r <= PSOC_PRELOAD_RESET;
      vernier_offset_value_r <= PSOC_VERNIER_OFFSET_VALUE_RESET;
    end
    else if (cfg_wr_i)
    begin
      unique case (cfg_addr_i)
        PSOC_IDX_SERIAL_CFG: cfg_r <= cfg_wdata_i & PSOC_CFG_WMASK;
        PSOC_IDX_PRELOAD_ONE: pre1_r <= cfg_wdata_i;
        PSOC_IDX_PRELOAD_TWO: pre2_r <= cfg_wdata_i;
        PSOC_IDX_VERNIER_VERNIER_OFFSET_VALUE: vernier_offset_value_r <= cfg_wdata_i;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Register reads, one cycle latency
  wire logic [31:0] rd_mux;      // Selected read value
  assign rd_mux = (cfg_addr_i == PSOC_IDX_SERIAL_CFG) ? cfg_r :
                  (cfg_addr_i == PSOC_IDX_PRELOAD_ONE) ? pre1_r :
                  (cfg_addr_i == PSOC_IDX_PRELOAD_TWO) ? pre2_r : vernier_offset_value_r;

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cfg_rdata_o <= 32'h0000_0000;
      cfg_rvalid_o <= 1'b0;
    end
    else
    begin
      cfg_rvalid_o <= cfg_rd_i;
      if (cfg_rd_i) cfg_rdata_o <= rd_mux;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Strap capture shortly after reset release
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      strap_sync_r <= 3'h7;
      strap_cnt_r <= 2'h0;
      strap_done_r <= 1'b0;
      strap_en_r <= 1'b0;
    end
    else
    begin
      strap_sync_r <= {strap_sync_r[1:0], interface_enable_strap_i};
      if (!strap_done_r)
      begin
        if (strap_cnt_r == PSOC_STRAP_SETTLE)
        begin
          // Capture only once the last two stages agree
          if (strap_sync_r[1] == strap_sync_r[2])
          begin
            strap_done_r <= 1'b1;
            strap_en_r <= ~strap_sync_r[2]; // Low strap enables
          end
        end
        else strap_cnt_r <= strap_cnt_r + 2'h1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Snapshot for the link: refreshed after reset and at each timeout,
  // so it stays still while a frame may start
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      prime_r <= 1'b1;
      word_r <= 32'h0000_0000;
      frame_long_r <= 1'b0;
      ring_r <= 1'b0;
    end
    else if (prime_r || rearm)
    begin
      prime_r <= 1'b0;
      word_r <= fmt_pos;
      frame_long_r <= ~frame_long; // Set bit means 20-bit frame
      ring_r <= ring;
    end
  end

  assign lk.word = word_r;
  assign lk.frame_long = frame_long_r;
  assign lk.ring = ring_r;
  assign lk.rearm = rearm;

  //////////////////////////////////////////////////////////////////////
  // Submodules
  psoc_timeout u_tmo (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .act_toggle_i(lk.act_toggle),
    .limit_i(limit),
    .busy_o(busy),
    .rearm_o(rearm)
  );

  psoc_link_ser u_ser (
    .link_clk_i(link_clk_i),
    .rst_n_i(rst_n_i),
    .lk(lk),
    .serial_data_o(serial_data_o)
  );

endmodule // psoc_top
`default_nettype wire

//--- verification/psoc_ssi_master.sv
// Link master model that clocks position frames out of the device
`timescale 1ns/1ps
`default_nettype none
module psoc_ssi_master
(
  output logic link_clk_o,       // Link clock, stands low between frames
  input wire logic serial_data_i // Serial data from the device
);
  //////////////////////////////////////////////////////////////////////
  // Clock is idle low until a frame is requested
  initial link_clk_o = 1'b0;

  // Clock n periods of 12 ns and sample after each falling edge
  task automatic run_frame(input int n, output logic [32:0] bits);
    bits = '0;
    repeat (n)
    begin
      #6 link_clk_o = 1'b1;
      #6 link_clk_o = 1'b0;
      bits = {bits[31:0], serial_data_i}; // MSB arrives first
    end
  endtask
endmodule // psoc_ssi_master
`default_nettype wire

//--- verification/psoc_top_checker.sv
// Concurrent checks on the ports of the position output block
`timescale 1ns/1ps
`default_nettype none
module psoc_top_checker
  import psoc_pkg::*;
(
  input wire logic clk_i,                       // Clock
  input wire logic rst_n_i,                     // Reset, active low
  input wire logic reference_position_select_i, // Reference select
  input wire logic cfg_wr_i,                    // Write strobe
  input wire logic cfg_rd_i,                    // Read strobe
  input wire logic [1:0] cfg_addr_i,            // Register index
  input wire logic [31:0] cfg_wdata_i,          // Write data
  input wire logic [31:0] cfg_rdata_o,          // Read data
  input wire logic cfg_rvalid_o,                // Read valid
  input wire logic serial_enable_o,             // Interface on
  input wire logic ssi_mode_o,                  // SSI mode
  input wire logic biss_mode_o,                 // BiSS mode
  input wire logic wide_read_o,                 // Wide reads
  input wire logic [31:0] preload_one_o,        // Preload one
  input wire logic [31:0] preload_two_o,        // Preload two
  input wire logic [31:0] vernier_offset_o,     // Offset
  input wire logic [15:0] ref_pos_first_o,      // Reference one
  input wire logic [15:0] ref_pos_second_o,     // Reference two
  input wire logic ref_pos_valid_o              // References in use
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // Read strobe followed by valid one cycle later
  sequence rd_answer_s;
    cfg_rd_i ##1 cfg_rvalid_o;
  endsequence
  //////////////////////////////////////////////////////////////////////
  read_answer_a: assert property (cfg_rd_i |-> rd_answer_s)
    else $error("read strobe not answered");
  no_spurious_a: assert property (!cfg_rd_i |=> !cfg_rvalid_o)
    else $error("read valid without read");
  pre_one_wr_a: assert property (cfg_wr_i && cfg_addr_i == PSOC_IDX_PRELOAD_ONE
    |=> preload_one_o == $past(cfg_wdata_i)) else $error("preload one not written");
  pre_two_wr_a: assert property (cfg_wr_i && cfg_addr_i == PSOC_IDX_PRELOAD_TWO
    |=> preload_two_o == $past(cfg_wdata_i)) else $error("preload two not written");
  vernier_offset_value_wr_a: assert property (cfg_wr_i && cfg_addr_i == PSOC_IDX_VERNIER_VERNIER_OFFSET_VALUE
    |=> vernier_offset_o == $past(cfg_wdata_i)) else $error("offset not written");
  vernier_offset_value_hold_a: assert property (!cfg_wr_i |=> $stable(vernier_offset_o))
    else $error("offset changed without write");
  ref_split_a: assert property (ref_pos_valid_o == reference_position_select_i
    && ref_pos_first_o == vernier_offset_o[15:0] && ref_pos_second_o == vernier_offset_o[31:16])
    else $error("reference halves wrong");
  mode_excl_a: assert property ((ssi_mode_o || biss_mode_o) == serial_enable_o
    && !(ssi_mode_o && biss_mode_o)) else $error("interface mode wrong");
  wide_wr_a: assert property (cfg_wr_i && cfg_addr_i == PSOC_IDX_SERIAL_CFG
    |=> wide_read_o == $past(cfg_wdata_i[6])) else $error("read width not taken");
  rdata_pre_a: assert property (cfg_rd_i && cfg_addr_i == PSOC_IDX_PRELOAD_ONE
    |=> cfg_rdata_o == $past(preload_one_o)) else $error("preload read wrong");
endmodule // psoc_top_checker
`default_nettype wire

//--- verification/tb_top.sv
// Register and frame tests of the position output block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import psoc_pkg::*;
  logic clk_i, rst_n_i, link_clk, strap, ref_sel, wr, rd, rvalid, sdata, interface_enable_strap, ssi, biss, wide;
  logic [1:0] addr;
  logic [31:0] wdata, rdata, p1, p2, vernier_offset_value;
  logic [15:0] r1, r2;
  logic rvld, fact;
  logic [32:0] bits;
  logic [31:0] got, exp_w;
  int fail_count, comparisons, cyc, n;
  logic w20s [5] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
  logic rings [5] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
  logic [1:0] srcs [5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h0};
  logic grays [5] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0}; // No Gray with debug source
  logic [4:0] ress [5] = '{5'h1e, 5'h08, 5'h0c, 5'h08, 5'h1e};
  localparam logic [31:0] VPOS = 32'h3abc_def1;
  localparam logic [31:0] CH1 = 32'h0001_a5c3;
  localparam logic [31:0] CH2 = 32'h8000_7e19;
  //////////////////////////////////////////////////////////////////////
  psoc_top dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .link_clk_i(link_clk),
    .interface_enable_strap_i(strap), .reference_position_select_i(ref_sel),
    .cfg_wr_i(wr), .cfg_rd_i(rd), .cfg_addr_i(addr), .cfg_wdata_i(wdata),
    .cfg_rdata_o(rdata), .cfg_rvalid_o(rvalid), .vernier_pos_i(VPOS), .ch1_count_i(CH1),
    .ch2_count_i(CH2), .serial_enable_o(interface_enable_strap), .ssi_mode_o(ssi), .biss_mode_o(biss),
    .wide_read_o(wide), .preload_one_o(p1), .preload_two_o(p2), .vernier_offset_o(vernier_offset_value),
    .ref_pos_first_o(r1), .ref_pos_second_o(r2), .ref_pos_valid_o(rvld),
    .frame_active_o(fact), .serial_data_o(sdata));
  psoc_ssi_master master_u (.link_clk_o(link_clk), .serial_data_i(sdata));
  //////////////////////////////////////////////////////////////////////
  // Clock of 8 ns
  initial
  begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  // Compare tasks
  task automatic chk32(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk1(input string nm, input logic e, input logic g);
    chk32(nm, {31'h0, e}, {31'h0, g});
  endtask
  // Register access on the configuration port
  task automatic wr_reg(input logic [1:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk_i);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [1:0] a, output logic [31:0] d);
    @(posedge clk_i);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk_i);
    rd <= 1'b0;
    #1;
    chk1("read valid", 1'b1, rvalid);
    d = rdata;
  endtask
  // Wait for the frame timeout, counting clock cycles
  task automatic wait_idle(output int c);
    logic seen;
    seen = 1'b0;
    c = 0;
    while (c < 3000 && !(seen && fact === 1'b0))
    begin
      @(posedge clk_i);
      #1;
      seen = seen | (fact === 1'b1);
      c++;
    end
    if (c >= 3000) fail_count++; // Limit ran out
    // Let rearm and snapshot refresh pass before the next frame
    repeat (2) @(posedge clk_i);
  endtask
  // Serial config word from its fields
  function automatic logic [31:0] mk(logic w, logic rg, logic [1:0] s, logic g,
                                     logic [4:0] r, logic si);
    mk = {si, 1'b0, w, rg, 12'h014, s, g, r, 3'h0, 5'h09};
  endfunction
  // Expected frame word from config and sources
  function automatic logic [31:0] expect_word(logic [31:0] c);
    logic [31:0] v;
    v = (c[15:14] == 2'h0) ? VPOS : (c[15:14] == 2'h1) ? CH1 :
        (c[15:14] == 2'h2) ? CH2 : {CH1[15:0], CH2[15:0]};
    if (c[15:14] != 2'h3)
      v = v & ~(32'hffff_ffff << c[12:8]);
    if (c[13])
      v = v ^ (v >> 1);
    expect_word = c[29] ? {12'h0, v[19:0]} : v;
  endfunction
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Watchdog
  initial
  begin
    repeat (20000) @(posedge clk_i);
    fail_count++;
    end_of_test();
  end
  //////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    fail_count = 0;
    comparisons = 0;
    rst_n_i = 1'b0;
    strap = 1'b0;
    ref_sel = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 2'h0;
    wdata = 32'h0;
    repeat (4) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    rd_reg(PSOC_IDX_SERIAL_CFG, got);
    chk32("cfg reset", 32'hb2051e09, got);
    for (int i = 1; i < 4; i++)
    begin
      rd_reg(i[1:0], got); // Whole aligned words in index order
      chk32("data reset", 32'h0, got);
    end
    chk1("ssi mode", 1'b1, ssi);
    chk1("serial enable", 1'b1, interface_enable_strap);
    $display("test reset done");
    wr_reg(PSOC_IDX_PRELOAD_ONE, 32'ha5a5_0f0f);
    wr_reg(PSOC_IDX_PRELOAD_TWO, 32'h5a5a_f0f0);
    wr_reg(PSOC_IDX_VERNIER_VERNIER_OFFSET_VALUE, 32'h1234_5678);
    wr_reg(PSOC_IDX_SERIAL_CFG, 32'hffff_dfff); // No Gray with debug source
    rd_reg(PSOC_IDX_SERIAL_CFG, got);
    chk32("cfg mask", 32'hbfffdf5f, got);
    chk32("offset", 32'h1234_5678, vernier_offset_value);
    chk1("wide read", 1'b1, wide);
    chk32("preload one", 32'ha5a5_0f0f, p1);
    chk32("preload two", 32'h5a5a_f0f0, p2);
    @(posedge clk_i);
    ref_sel <= 1'b1;
    @(posedge clk_i);
    #1;
    chk32("references", 32'h1234_5678, {r2, r1});
    chk1("reference valid", 1'b1, rvld);
    $display("test registers done");
    for (int i = 0; i < 5; i++)
    begin
      exp_w = mk(w20s[i], rings[i], srcs[i], grays[i], ress[i], 1'b1);
      wr_reg(PSOC_IDX_SERIAL_CFG, exp_w); // Configured before any frame
      master_u.run_frame(1, bits);
      wait_idle(cyc);
      n = w20s[i] ? 20 : 32;
      master_u.run_frame(n + 1, bits);
      got = w20s[i] ? {12'h0, bits[20:1]} : bits[32:1];
      chk32("frame word", expect_word(exp_w), got);
      chk1("after last bit", rings[i] ? got[n - 1] : 1'b0, bits[0]);
      wait_idle(cyc);
      chk1("ssi timeout", 1'b1, cyc >= 23 && cyc <= 29);
    end
    $display("test frames done");
    wr_reg(PSOC_IDX_SERIAL_CFG, (mk(1'b1, 1'b0, 2'h0, 1'b0, 5'h1e, 1'b0) & 32'hffff_ffe0) | 32'h5);
    #1;
    chk1("biss mode", 1'b1, biss);
    master_u.run_frame(1, bits);
    wait_idle(cyc);
    master_u.run_frame(1, bits);
    wait_idle(cyc);
    chk1("biss timeout", 1'b1, cyc >= 32 && cyc <= 38);
    $display("test biss done");
    end_of_test();
  end
endmodule // tb_top

bind psoc_top psoc_top_checker chk_u (.clk_i(clk_i), .rst_n_i(rst_n_i),
  .reference_position_select_i(reference_position_select_i), .cfg_wr_i(cfg_wr_i),
  .cfg_rd_i(cfg_rd_i), .cfg_addr_i(cfg_addr_i), .cfg_wdata_i(cfg_wdata_i),
  .cfg_rdata_o(cfg_rdata_o), .cfg_rvalid_o(cfg_rvalid_o), .serial_enable_o(serial_enable_o),
  .ssi_mode_o(ssi_mode_o), .biss_mode_o(biss_mode_o), .wide_read_o(wide_read_o),
  .preload_one_o(preload_one_o), .preload_two_o(preload_two_o),
  .vernier_offset_o(vernier_offset_o), .ref_pos_first_o(ref_pos_first_o),
  .ref_pos_second_o(ref_pos_second_o), .ref_pos_valid_o(ref_pos_valid_o));
`default_nettype wire
